// >>> shared/tcs_cfg.svh
// Offsets, field positions, reset values for the cycle status block.
// Assumes a 32-bit AXI4-Lite register bus, byte addresses.
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_OFF_STAT_A   12'h000
`define TCS_OFF_STAT_B   12'h004
`define TCS_OFF_IRQ_STAT 12'h008
`define TCS_OFF_IRQ_MASK 12'h00C
`define TCS_OFF_MODE     12'h010
`define TCS_FLAG_LSB     0
`define TCS_DIR_LSB      4
`define TCS_STAT_W       16
`define TCS_RST_STAT     16'h0000
`define TCS_RST_MASK     8'h00
`define TCS_RST_MODE     1'b0
`endif

// >>> shared/tcs_pkg.sv
// Types shared by the cycle status block.
// Assumes tcs_cfg.svh supplies the numeric constants.
package tcs_pkg;
   // One sub-counter's live inputs
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] limit;
      logic        down;
   } tcs_sub_t;
   // Read tracking for the clear protocol
   typedef enum logic [1:0] {RD_IDLE, RD_DATA} tcs_rd_state_t;
endpackage

// >>> rtl/tcs_top.sv
// Cycle status registers for two timer channels, four sub-counters each.
// Assumes counters, limits and directions arrive synchronous to aclk.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"

// Contract
// - Upper byte of both status registers always reads zero.
// - First channel bits 7..4 show down-count direction of D..A.
// - Second channel direction bits always read zero.
// - Bits 3..0 hold cycle-match flags D..A, bit 0 for A.
// - Normal mode: flag sets when counter equals its cycle limit.
// - Complementary mode: flag sets when first channel hits zero down.
// - Flag clears by write of 0 after reading it as 1, or by write of 1 to its bit in the interrupt status register.
// - Writing 1 to a flag in a status register has no effect.
// - All flags, mask and mode are zero after reset; first channel direction bits follow the live down inputs.
module tcs_top #(
   parameter int N_SUB = 4
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire tcs_pkg::tcs_sub_t [3:0] sub_a,
   input  wire tcs_pkg::tcs_sub_t [3:0] sub_b,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   output logic [1:0]                   s_axi_bresp,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   input  wire logic [11:0]             s_axi_araddr,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         irq
);

   initial begin
      if (N_SUB != 4) begin
         $error("tcs_top serves exactly four sub-counters");
      end
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   // Status word of one channel
   function automatic logic [15:0] stat_word(input logic [3:0] dir,
                                             input logic [3:0] flg);
      stat_word = {8'h00, dir, flg};
   endfunction

   // ==========================================================
   // Flag set events
   // ==========================================================
   logic       compl_q;
   logic       compl_d;
   logic [3:0] set_a;
   logic [3:0] set_b;
   logic [3:0] dir_a;

   // Match or zero-in-down-count per sub-counter
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dir_a[i] = sub_a[i].down;
         if (compl_q) begin
            set_a[i] = sub_a[i].down && (sub_a[i].count == 16'h0000);
            set_b[i] = set_a[i];
         end else begin
            set_a[i] = (sub_a[i].count == sub_a[i].limit);
            set_b[i] = (sub_b[i].count == sub_b[i].limit);
         end
      end
   end

   // ==========================================================
   // Register bus state
   // ==========================================================
   logic        aw_q, aw_d, w_q, w_d, b_q, b_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        rv_q, rv_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d, bresp_q, bresp_d;
   logic [3:0]  flg_a_q, flg_a_d, flg_b_q, flg_b_d;
   logic [3:0]  arm_a_q, arm_a_d, arm_b_q, arm_b_d;
   logic [7:0]  mask_q, mask_d;
   logic        do_wr, do_rd, hit;
   logic [3:0]  clr_a, clr_b;

   assign s_axi_awready = !aw_q && !b_q;
   assign s_axi_wready  = !w_q && !b_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_bvalid  = b_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign do_wr = aw_q && w_q && !b_q;
   assign do_rd = s_axi_arvalid && !rv_q;

   // Next state of bus, flags, arming and control
   always_comb begin
      aw_d = aw_q; w_d = w_q; b_d = b_q;
      awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
      bresp_d = bresp_q; rv_d = rv_q; rdata_d = rdata_q;
      rresp_d = rresp_q; mask_d = mask_q; compl_d = compl_q;
      arm_a_d = arm_a_q; arm_b_d = arm_b_q;
      clr_a = 4'h0; clr_b = 4'h0; hit = 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1; awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1; wdata_d = s_axi_wdata; wstrb_d = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1;
         case (awaddr_q[11:2])
            `TCS_OFF_STAT_A >> 2: begin
               if (wstrb_q[0]) clr_a = arm_a_q & ~wdata_q[3:0];
               arm_a_d = arm_a_q & ~clr_a;
            end
            `TCS_OFF_STAT_B >> 2: begin
               if (wstrb_q[0]) clr_b = arm_b_q & ~wdata_q[3:0];
               arm_b_d = arm_b_q & ~clr_b;
            end
            `TCS_OFF_IRQ_STAT >> 2: begin
               if (wstrb_q[0]) begin
                  clr_a = wdata_q[3:0] & flg_a_q;
                  clr_b = wdata_q[7:4] & flg_b_q;
               end
            end
            `TCS_OFF_IRQ_MASK >> 2: if (wstrb_q[0]) mask_d = wdata_q[7:0];
            `TCS_OFF_MODE >> 2: if (wstrb_q[0]) compl_d = wdata_q[0];
            default: hit = 1'b0;
         endcase
         bresp_d = hit ? 2'b00 : 2'b10;
      end
      if (b_q && s_axi_bready) b_d = 1'b0;
      if (rv_q && s_axi_rready) rv_d = 1'b0;
      if (do_rd) begin
         rv_d = 1'b1; rresp_d = 2'b00; rdata_d = 32'h0000_0000;
         case (s_axi_araddr[11:2])
            `TCS_OFF_STAT_A >> 2: begin
               rdata_d[15:0] = stat_word(dir_a, flg_a_q);
               arm_a_d = flg_a_q; // arm on read of 1
            end
            `TCS_OFF_STAT_B >> 2: begin
               rdata_d[15:0] = stat_word(4'h0, flg_b_q);
               arm_b_d = flg_b_q;
            end
            `TCS_OFF_IRQ_STAT >> 2: rdata_d[7:0] = {flg_b_q, flg_a_q};
            `TCS_OFF_IRQ_MASK >> 2: rdata_d[7:0] = mask_q;
            `TCS_OFF_MODE >> 2: rdata_d[0] = compl_q;
            default: rresp_d = 2'b10;
         endcase
      end
      // flags in bits 3..0, set beats clear
      flg_a_d = (flg_a_q & ~clr_a) | set_a;
      flg_b_d = (flg_b_q & ~clr_b) | set_b;
   end

   // Register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0;
         awaddr_q <= 12'h000; wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0; bresp_q <= 2'b00;
         rv_q <= 1'b0; rdata_q <= 32'h0000_0000; rresp_q <= 2'b00;
         flg_a_q <= 4'h0; flg_b_q <= 4'h0;
         arm_a_q <= 4'h0; arm_b_q <= 4'h0;
         mask_q <= `TCS_RST_MASK; compl_q <= `TCS_RST_MODE;
      end else begin
         aw_q <= aw_d; w_q <= w_d; b_q <= b_d;
         awaddr_q <= awaddr_d; wdata_q <= wdata_d;
         wstrb_q <= wstrb_d; bresp_q <= bresp_d;
         rv_q <= rv_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
         flg_a_q <= flg_a_d; flg_b_q <= flg_b_d;
         arm_a_q <= arm_a_d; arm_b_q <= arm_b_d;
         mask_q <= mask_d; compl_q <= compl_d;
      end
   end

   // Interrupt level from unmasked flags
   assign irq = |({flg_b_q, flg_a_q} & mask_q);

endmodule
`default_nettype wire

// >>> test/tcs_checker.sv
// Bus timing and reserved-bit checks for tcs_top.
// Assumes one clock domain and a bind onto tcs_top.
`timescale 1ns/1ns
`default_nettype none
// ===========================
// Checker
module tcs_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshake steps
   sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   rsv_zero_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
   wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("write answer dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   aw_block_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken busy");
   reset_quiet_a: assert property ($rose(aresetn) |->
      !irq && !s_axi_rvalid && !s_axi_bvalid) else $error("not idle");
endmodule
bind tcs_top tcs_checker u_tcs_checker (.*);
`default_nettype wire

// >>> test/tcs_top_tb.sv
// Self-checking bench for tcs_top over AXI4-Lite.
// Assumes tcs_cfg.svh offsets and the hand-over bus timing.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
 $display("Error at %0t got %h expected %h", $time, a, e); end end
// ===========================
// Bench
module tcs_top_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, irq;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, ad, dd;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   tcs_pkg::tcs_sub_t [3:0] sub_a, sub_b;
   int n_errors, num_checks, cyc;
   tcs_top u_tcs_top (.*);
   // Clock and hang limit
   initial begin aclk = 0; forever #5 aclk = ~aclk; end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin n_errors++; report_and_stop(); end
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      ad = 1'b0;
      dd = 1'b0;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
         if (s_axi_wready) begin dd = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h1;
      @(posedge aclk);
      `CHK(s_axi_bresp, e)
      s_axi_bready <= 1'h0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      {rv, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
      `CHK({rv, rr}, {e, r})
   endtask
   task t_dir;
      @(posedge aclk);
      {sub_a[3].down, sub_a[1].down, sub_b[0].down} <= 3'h7;
      rchk(`TCS_OFF_STAT_A, 32'h0000_00A0, 2'h0);
      rchk(`TCS_OFF_STAT_B, 32'h0000_0000, 2'h0);
      {sub_a[3].down, sub_a[1].down, sub_b[0].down} <= 3'h0;
      $display("direction test done");
   endtask
   task t_flag;
      @(posedge aclk);
      {sub_a[2].limit, sub_b[3].limit} <= 32'h0000_0000;
      @(posedge aclk);
      {sub_a[2].limit, sub_b[3].limit} <= 32'h0001_0001;
      wr(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0004, 2'h0);
      wr(`TCS_OFF_STAT_A, 32'h0000_000F, 2'h0);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0004, 2'h0);
      wr(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_B, 32'h0000_0008, 2'h0);
      `CHK(irq, 1'h0)
      wr(`TCS_OFF_IRQ_MASK, 32'h0000_0080, 2'h0);
      `CHK(irq, 1'h1)
      wr(`TCS_OFF_IRQ_STAT, 32'h0000_0080, 2'h0);
      `CHK(irq, 1'h0)
      wr(12'h020, 32'h0000_0000, 2'h2);
      rchk(12'h020, 32'h0000_0000, 2'h2);
      $display("flag test done");
   endtask
   task t_race;
      @(posedge aclk);
      sub_a[0].limit <= 16'h0000;
      rchk(`TCS_OFF_STAT_A, 32'h0000_0001, 2'h0);
      wr(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0001, 2'h0);
      sub_a[0].limit <= 16'h0001;
      @(posedge aclk);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0001, 2'h0);
      wr(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      $display("race test done");
   endtask
   task t_comp;
      wr(`TCS_OFF_MODE, 32'h0000_0001, 2'h0);
      {sub_a[1].down, sub_b[2].limit} <= 17'h1_0000;
      rchk(`TCS_OFF_STAT_A, 32'h0000_0022, 2'h0);
      rchk(`TCS_OFF_STAT_B, 32'h0000_0002, 2'h0);
      $display("complementary test done");
   endtask
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
      {s_axi_wdata, s_axi_wstrb} = 36'hF;
      for (int i = 0; i < 4; i++) begin
         sub_a[i] = '{count: 16'h0000, limit: 16'h0001, down: 1'h0};
         sub_b[i] = sub_a[i];
      end
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rchk(`TCS_OFF_STAT_A, 32'h0000_0000, 2'h0);
      rchk(`TCS_OFF_STAT_B, 32'h0000_0000, 2'h0);
      t_dir();
      t_flag();
      t_race();
      t_comp();
      report_and_stop();
   end
endmodule
`default_nettype wire
